// ===== include/slot_b_afe_defs.svh
// offsets, field positions, reset values and path codes of the slot b afe bank
`ifndef SLOT_B_AFE_DEFS_SVH
`define SLOT_B_AFE_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define AMP_SET_ADDR 8'h44
`define PATH_SEL_ADDR 8'h45

// ****************************************
// field positions of the amplifier settings word
// ****************************************
`define AMP_SET_WIDTH 10
`define INT_GAIN_MSB 9
`define INT_GAIN_LSB 8
`define INT_BUF_BIT 7
`define IND_EN_BIT 6
`define VREF_MSB 5
`define VREF_LSB 4
`define RSVD_MSB 3
`define RSVD_LSB 2
`define AMP_GAIN_MSB 1
`define AMP_GAIN_LSB 0

// ****************************************
// reset values and codes
// ****************************************
`define AMP_SET_RESET 10'h038
`define INT_GAIN_RESET 2'h0
`define INT_BUF_RESET 1'h0
`define IND_EN_RESET 1'h0
`define VREF_RESET 2'h3
`define RSVD_RESET 2'h2
`define AMP_GAIN_RESET 2'h0
`define PATH_SEL_RESET 16'hada5
`define PATH_CODE_FULL 16'hada5
`define PATH_CODE_BUF 16'hae65
`define PATH_CODE_DIRECT 16'hb065
`define INT_GAIN_REDUCED 2'h2
`define COMPANION_BUF_BIT 7

`endif

// ===== include/slot_b_afe_pkg.sv
// types shared by the slot b afe configuration bank
package slot_b_afe_pkg;

   // ****************************************
   // register access request
   // ****************************************
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [15:0] wdata;
   } reg_req_s;

   // ****************************************
   // decoded path mode
   // ****************************************
   typedef enum logic [1:0] {
      PATH_FULL_ANALOG = 2'b00,
      PATH_AMP_ADC_BUF = 2'b01,
      PATH_AMP_ADC_DIRECT = 2'b10,
      PATH_RESERVED = 2'b11
   } path_mode_e;

   // ****************************************
   // controls toward the analog front end
   // ****************************************
   typedef struct packed {
      logic [1:0] second_slot_integrator_gain;
      logic second_slot_integrator_buffer_select;
      logic buffer_gain_reduced;
      logic second_slot_per_channel_gain_enable;
      logic [1:0] second_slot_amplifier_reference;
      logic [3:0][1:0] channel_gain;
      path_mode_e path_mode;
   } afe_ctrl_s;

endpackage

// ===== rtl/slot_b_afe_config_regs.sv
// slot b analog front end configuration register bank
//
// Behaviour
// - integrator gain bits 9:8 pick 400k, 200k or 100k resistor in normal mode.
// - as buffer in amp-to-adc mode, codes 00/01 give gain 1.0, 10 gives 0.7.
// - bit 7 turns integrator into buffer; resets to 0.
// - bit 6 enables per-channel gains; channels 2-4 come from register 0x55.
// - reference bits 5:4 select 1.14/1.01/0.90/1.27 V; resets to 3.
// - amplifier gain bits 1:0 select 200k/100k/50k/25k; resets to 0.
// - gain field drives all four channels unless per-channel enable is set.
// - path register at 0x45 resets to 0xada5, the full analog path.
// - 0xb065 means amp-to-adc mode; used only with buffer bit clear.
`timescale 1ns/10ps
`include "slot_b_afe_defs.svh"

module slot_b_afe_config_regs (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // register access from the serial control port
   input wire slot_b_afe_pkg::reg_req_s reg_req,
   output logic [15:0] reg_rdata,
   // gains of channels 2 to 4 and companion buffer enable
   input wire logic [5:0] ext_channel_gain,
   input wire logic [15:0] companion_cfg,
   // front end controls and status
   output slot_b_afe_pkg::afe_ctrl_s afe_ctrl,
   output logic path_misconfig
);
   import slot_b_afe_pkg::*;

   // ****************************************
   // decode helpers
   // ****************************************
   function automatic path_mode_e decode_path(input logic [15:0] code);
      path_mode_e m;
      m = PATH_RESERVED;
      if (code == `PATH_CODE_FULL) begin
         m = PATH_FULL_ANALOG;
      end else if (code == `PATH_CODE_BUF) begin
         m = PATH_AMP_ADC_BUF;
      end else if (code == `PATH_CODE_DIRECT) begin
         m = PATH_AMP_ADC_DIRECT;
      end
      return m;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction

   // ****************************************
   // storage
   // ****************************************
   logic amp_wr;
   logic path_wr;
   logic [1:0] int_gain_reg;
   logic int_buf_reg;
   logic ind_en_reg;
   logic [1:0] vref_reg;
   logic [1:0] rsvd_reg;
   logic [1:0] amp_gain_reg;
   logic [15:0] path_sel_reg;
   logic [`AMP_SET_WIDTH-1:0] amp_set_word;
   logic [15:0] rdata_next;
   path_mode_e mode_next;
   logic [3:0][1:0] gain_next;
   logic reduced_next;
   logic misconfig_next;
   logic [1:0] int_gain_out_reg;
   logic int_buf_out_reg;
   logic reduced_out_reg;
   logic ind_en_out_reg;
   logic [1:0] vref_out_reg;
   logic [3:0][1:0] gain_out_reg;
   path_mode_e mode_out_reg;

   // ****************************************
   // write decode
   // ****************************************
   assign amp_wr = reg_req.wr && hit(reg_req.addr, `AMP_SET_ADDR);
   assign path_wr = reg_req.wr && hit(reg_req.addr, `PATH_SEL_ADDR);
   assign amp_set_word = {int_gain_reg, int_buf_reg, ind_en_reg, vref_reg,
      rsvd_reg, amp_gain_reg};

   // ****************************************
   // amplifier settings fields
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         int_gain_reg <= `INT_GAIN_RESET;
      end else if (amp_wr) begin
         int_gain_reg <= reg_req.wdata[`INT_GAIN_MSB:`INT_GAIN_LSB];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         int_buf_reg <= `INT_BUF_RESET;
      end else if (amp_wr) begin
         int_buf_reg <= reg_req.wdata[`INT_BUF_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ind_en_reg <= `IND_EN_RESET;
      end else if (amp_wr) begin
         ind_en_reg <= reg_req.wdata[`IND_EN_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         vref_reg <= `VREF_RESET;
      end else if (amp_wr) begin
         vref_reg <= reg_req.wdata[`VREF_MSB:`VREF_LSB];
      end
   end

   // reserved bits are kept as written so software can read them back
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rsvd_reg <= `RSVD_RESET;
      end else if (amp_wr) begin
         rsvd_reg <= reg_req.wdata[`RSVD_MSB:`RSVD_LSB];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         amp_gain_reg <= `AMP_GAIN_RESET;
      end else if (amp_wr) begin
         amp_gain_reg <= reg_req.wdata[`AMP_GAIN_MSB:`AMP_GAIN_LSB];
      end
   end

   // ****************************************
   // path select word
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         path_sel_reg <= `PATH_SEL_RESET;
      end else if (path_wr) begin
         path_sel_reg <= reg_req.wdata;
      end
   end

   // ****************************************
   // read port
   // ****************************************
   // unmapped offsets read zero; upper mode bits live elsewhere
   always_comb begin
      rdata_next = 16'h0000;
      if (hit(reg_req.addr, `AMP_SET_ADDR)) begin
         rdata_next = {6'h00, amp_set_word};
      end else if (hit(reg_req.addr, `PATH_SEL_ADDR)) begin
         rdata_next = path_sel_reg;
      end
   end

   // a read in the cycle of a write returns the old word
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 16'h0000;
      end else if (reg_req.rd) begin
         reg_rdata <= rdata_next;
      end
   end

   // ****************************************
   // channel gain steering
   // ****************************************
   assign gain_next[0] = amp_gain_reg;
   genvar ch;
   generate
      for (ch = 1; ch < 4; ch++) begin : g_chan
         assign gain_next[ch] = ind_en_reg ?
            ext_channel_gain[2*ch-1 -: 2] :
            amp_gain_reg;
      end
   endgenerate

   // ****************************************
   // path decode
   // ****************************************
   assign mode_next = decode_path(path_sel_reg);

   function automatic logic gain_reduced(input logic buf_sel,
      input path_mode_e mode, input logic [1:0] gain);
      return buf_sel && (mode == PATH_AMP_ADC_BUF) &&
         (gain == `INT_GAIN_REDUCED);
   endfunction

   assign reduced_next = gain_reduced(int_buf_reg, mode_next,
      int_gain_reg);

   // ****************************************
   // front end control flops
   // ****************************************
   // registered so the analog side never sees a decode glitch
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         int_gain_out_reg <= `INT_GAIN_RESET;
      end else begin
         int_gain_out_reg <= int_gain_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         int_buf_out_reg <= `INT_BUF_RESET;
      end else begin
         int_buf_out_reg <= int_buf_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reduced_out_reg <= 1'h0;
      end else begin
         reduced_out_reg <= reduced_next;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ind_en_out_reg <= `IND_EN_RESET;
      end else begin
         ind_en_out_reg <= ind_en_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         vref_out_reg <= `VREF_RESET;
      end else begin
         vref_out_reg <= vref_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         gain_out_reg <= {4{`AMP_GAIN_RESET}};
      end else begin
         gain_out_reg <= gain_next;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_out_reg <= PATH_FULL_ANALOG;
      end else begin
         mode_out_reg <= mode_next;
      end
   end

   // ****************************************
   // front end control word
   // ****************************************
   // every field comes straight from its own flop
   assign afe_ctrl = '{
      second_slot_integrator_gain: int_gain_out_reg,
      second_slot_integrator_buffer_select: int_buf_out_reg,
      buffer_gain_reduced: reduced_out_reg,
      second_slot_per_channel_gain_enable: ind_en_out_reg,
      second_slot_amplifier_reference: vref_out_reg,
      channel_gain: gain_out_reg,
      path_mode: mode_out_reg
   };

   // ****************************************
   // misconfiguration status
   // ****************************************
   // flags only; the path code is still applied as written
   always_comb begin
      misconfig_next = 1'h0;
      unique case (mode_next)
         PATH_FULL_ANALOG: begin
            misconfig_next = 1'h0;
         end
         PATH_AMP_ADC_BUF: begin
            misconfig_next = !int_buf_reg ||
               !companion_cfg[`COMPANION_BUF_BIT];
         end
         PATH_AMP_ADC_DIRECT: begin
            misconfig_next = int_buf_reg;
         end
         PATH_RESERVED: begin
            misconfig_next = 1'h1;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         path_misconfig <= 1'h0;
      end else begin
         path_misconfig <= misconfig_next;
      end
   end

endmodule

// ===== tb/slot_b_afe_config_regs_properties.sv
// assertions on the ports of the slot b afe bank
`timescale 1ns/10ps
module slot_b_afe_checker
   import slot_b_afe_pkg::*;
(
   // clock, reset and register side
   input wire logic core_clk,
   input wire logic rst_b,
   input wire slot_b_afe_pkg::reg_req_s reg_req,
   input wire logic [15:0] reg_rdata,
   // front end side
   input wire logic [5:0] ext_channel_gain,
   input wire logic [15:0] companion_cfg,
   input wire slot_b_afe_pkg::afe_ctrl_s afe_ctrl,
   input wire logic path_misconfig
);
   logic w44, w45;
   assign w44 = reg_req.wr && reg_req.addr == 8'h44;
   assign w45 = reg_req.wr && reg_req.addr == 8'h45;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_path_full: assert property (
      w45 && reg_req.wdata == 16'hada5 ##1 !w45
      |=> afe_ctrl.path_mode == PATH_FULL_ANALOG) else $error("path full");
   a_fields_follow: assert property (
      $past(w44, 2) && !$past(w44)
      |-> afe_ctrl.second_slot_amplifier_reference ==
      $past(reg_req.wdata[5:4], 2)
      && afe_ctrl.second_slot_integrator_gain == $past(reg_req.wdata[9:8], 2)
      && afe_ctrl.channel_gain[0] == $past(reg_req.wdata[1:0], 2)
      && afe_ctrl.second_slot_integrator_buffer_select ==
      $past(reg_req.wdata[7], 2))
      else $error("fields");
   a_common_gain: assert property (
      !afe_ctrl.second_slot_per_channel_gain_enable
      |-> afe_ctrl.channel_gain == {4{afe_ctrl.channel_gain[0]}})
      else $error("common");
   a_indiv_gain: assert property (
      afe_ctrl.second_slot_per_channel_gain_enable
      |-> afe_ctrl.channel_gain[3:1] == $past(ext_channel_gain))
      else $error("indiv");
   a_buf_gain: assert property (afe_ctrl.buffer_gain_reduced ==
      (afe_ctrl.second_slot_integrator_buffer_select && afe_ctrl.path_mode ==
      PATH_AMP_ADC_BUF && afe_ctrl.second_slot_integrator_gain == 2'h2))
      else $error("buf gain");
   a_misconfig_flag: assert property (path_misconfig ==
      (afe_ctrl.path_mode == PATH_RESERVED || (afe_ctrl.path_mode ==
      PATH_AMP_ADC_BUF && !(afe_ctrl.second_slot_integrator_buffer_select &&
      $past(companion_cfg[7]))) || (afe_ctrl.path_mode == PATH_AMP_ADC_DIRECT
      && afe_ctrl.second_slot_integrator_buffer_select)))
      else $error("misconfig");
   a_unmapped_read: assert property (reg_req.rd && reg_req.addr != 8'h44 &&
      reg_req.addr != 8'h45 |=> reg_rdata == 16'h0000) else $error("unmapped");
   a_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
      else $error("rdata hold");
endmodule

bind slot_b_afe_config_regs slot_b_afe_checker u_chk (.core_clk(core_clk),
   .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .ext_channel_gain(ext_channel_gain), .companion_cfg(companion_cfg),
   .afe_ctrl(afe_ctrl), .path_misconfig(path_misconfig));

// ===== tb/slot_b_afe_config_regs_tb_top.sv
// self-checking bench for the slot b afe bank
`timescale 1ns/10ps
module slot_b_afe_config_regs_tb_top;
   import slot_b_afe_pkg::*;
   logic core_clk = 1'b0, rst_b = 1'b0;
   reg_req_s req = '0;
   logic [15:0] rdata, comp = 16'h0;
   logic [5:0] ext = 6'h0;
   afe_ctrl_s ctl;
   logic mis;
   int fails = 0, total_checks = 0, cyc = 0;
   slot_b_afe_config_regs DUT (.core_clk(core_clk), .rst_b(rst_b),
      .reg_req(req), .reg_rdata(rdata), .ext_channel_gain(ext),
      .companion_cfg(comp), .afe_ctrl(ctl), .path_misconfig(mis));
   always #5 core_clk = ~core_clk;
   // hang guard, far above the hundred-odd cycles needed
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails = fails + 1;
         close_out;
      end
   end
   task chk(input string n, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge core_clk);
      req.wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge core_clk);
      req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0};
      @(posedge core_clk);
      req.rd <= 1'b0;
      @(negedge core_clk);
      chk("rdata", rdata, e);
   endtask
   // outputs trail the stored word by one edge
   task settle;
      repeat (2) @(negedge core_clk);
   endtask
   task t_reset;
      @(negedge core_clk);
      chk("vref", ctl.second_slot_amplifier_reference, 16'h3);
      chk("mode", ctl.path_mode, 16'h0);
      chk("misconfig", mis, 16'h0);
      rd(8'h44, 16'h0038);
      rd(8'h45, 16'hada5);
      rd(8'h46, 16'h0000);
   endtask
   task t_gain;
      logic [1:0] g;
      for (int i = 0; i < 4; i++) begin
         g = i[1:0];
         wr(8'h44, {6'h3f, g, 2'h0, g, 2'h1, g});
         settle;
         chk("int_gain", ctl.second_slot_integrator_gain, g);
         chk("vref", ctl.second_slot_amplifier_reference, g);
         chk("gains", ctl.channel_gain, {4{g}});
         rd(8'h44, {6'h0, g, 2'h0, g, 2'h1, g});
      end
   endtask
   task t_indiv;
      @(posedge core_clk);
      ext <= 6'h39;
      wr(8'h44, 16'h0046);
      settle;
      chk("ind_en", ctl.second_slot_per_channel_gain_enable, 16'h1);
      chk("gains", ctl.channel_gain, 8'he6);
      @(posedge core_clk);
      ext <= 6'h06;
      settle;
      chk("gains", ctl.channel_gain, 8'h1a);
   endtask
   task t_path(input logic [15:0] code, amp, input logic c7,
      input logic [1:0] mode, input logic m);
      @(posedge core_clk);
      comp <= {8'h0, c7, 7'h0};
      wr(8'h44, amp);
      wr(8'h45, code);
      settle;
      chk("mode", ctl.path_mode, mode);
      chk("misconfig", mis, m);
      chk("buf_sel", ctl.second_slot_integrator_buffer_select, amp[7]);
      chk("buf", ctl.buffer_gain_reduced,
         mode == 2'h1 && amp[7] && amp[9:8] == 2'h2);
      rd(8'h45, code);
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      t_reset;
      t_gain;
      t_indiv;
      t_path(16'hae65, 16'h02b4, 1'b1, 2'h1, 1'b0);
      t_path(16'hae65, 16'h00b4, 1'b0, 2'h1, 1'b1);
      t_path(16'hae65, 16'h0034, 1'b1, 2'h1, 1'b1);
      t_path(16'hb065, 16'h0034, 1'b0, 2'h2, 1'b0);
      t_path(16'hb065, 16'h00b4, 1'b1, 2'h2, 1'b1);
      t_path(16'h1234, 16'h0034, 1'b1, 2'h3, 1'b1);
      t_path(16'hada5, 16'h0034, 1'b0, 2'h0, 1'b0);
      close_out;
   end
endmodule
